/* File: include/uartc_defines.svh */
// Functional notes
// - Idle counter reloads from rx_idle_period on status read or received character.
// - Handshake gate off: CTS ignored, send whenever transmit data is offered.
// - Handshake gate on: start a character only while CTS is asserted.
// - Stop-count select: 0 gives one stop bit, 1 gives two.
// - Parity kind: even 0, odd 1, space 2 (always 0), mark 3 (always 1).
// - Parity-on bit enables transmit generation and receive checking together.
// - Character length select: 0 gives eight data bits, 1 gives seven.
// - Baud equals source clock over divisor, whole bits 15:3 plus fraction 2:0 / 8.
// - Source select: 0 26 MHz, 1 13 MHz, 2 6.5 MHz, 3 3.25 MHz.
// - Timeout flag rises when idle period elapses; status read clears it.
// - Frame fault flag set when the stop bit after the data is low.
// - Parity fault flag set when received parity differs from the expected one.
// - Seven-bit mode delivers received bytes with bit 7 forced to zero.
`ifndef UARTC_DEFINES_SVH
`define UARTC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define UARTC_ADDR_STATUS   32'h4000_4014
`define UARTC_ADDR_MASK     32'h4000_4018
`define UARTC_ADDR_IDLE     32'h4000_401c
`define UARTC_ADDR_FMT      32'h4000_4020
`define UARTC_ADDR_BAUD     32'h4000_4024
`define UARTC_ADDR_SRC      32'h4000_4028

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UARTC_FMT_RESET     6'h00
`define UARTC_BAUD_RESET    16'h0000
`define UARTC_SRC_RESET     2'h0
`define UARTC_IDLE_RESET    8'hff
`define UARTC_MASK_RESET    8'h00

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define UARTC_ST_FRAME      7
`define UARTC_ST_PARITY     5
`define UARTC_ST_TIMEOUT    4
`define UARTC_ST_IMPL       8'hb0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UARTC_REF_CLK_KHZ   125000
`define UARTC_SRC_BASE_KHZ  26000
`define UARTC_HALF_STEP     17'h00010

`endif

/* File: include/uartc_pkg.sv */
package uartc_pkg;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} uartc_tx_state_type;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_START  = 3'b001,
		RX_DATA   = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP   = 3'b100
	} uartc_rx_state_type;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} uartc_bus_req_type;

	typedef struct packed {
		logic       cts_gate;
		logic       stop2;
		logic [1:0] par_kind;
		logic       par_on;
		logic       char_len_sel;
	} uartc_fmt_type;

	// ----------------------------------------------------------------
	// State records
	// ----------------------------------------------------------------
	typedef struct packed {
		uartc_fmt_type      fmt;
		logic [15:0]        baud;
		logic [1:0]         src;
		logic [7:0]         idle;
		logic [7:0]         mask;
		logic [7:0]         stat;
		logic [31:0]        rdata;
		logic [2:0]         rxd_sync;
		logic               rxd_f;
		logic [2:0]         cts_sync;
		logic               cts_f;
		uartc_tx_state_type tx_st;
		logic [11:0]        tx_shift;
		logic [3:0]         tx_cnt;
		logic               tx_half;
		logic               txd;
		uartc_rx_state_type rx_st;
		logic [7:0]         rx_shift;
		logic [2:0]         rx_cnt;
		logic               rx_half;
		logic               rx_par;
		logic               rx_valid;
		logic [7:0]         rx_data;
		logic [7:0]         tmo_cnt;
		logic               tmo_armed;
		logic               tmo_half;
	} uartc_state_type;

	typedef struct packed {
		logic [16:0] src_acc;
		logic [16:0] div_acc;
		logic        tick;
	} uartc_baud_state_type;

endpackage

/* File: verilog/uartc_baud.sv */
`timescale 1ns/1ps
`include "uartc_defines.svh"
module uartc_baud import uartc_pkg::*; (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	// Configuration
	input  wire logic [1:0]  src_sel,
	input  wire logic [15:0] divisor,
	input  wire logic        restart,
	// Half-bit tick
	output logic             half_tick
);

	// ----------------------------------------------------------------
	// Two cascaded phase accumulators
	// ----------------------------------------------------------------
	// The source clock is emulated as an enable at an exact average rate,
	// so jitter is one reference period; fine for any sane baud.
	uartc_baud_state_type q;
	uartc_baud_state_type n;
	logic [17:0]          src_sum;
	logic [16:0]          src_step;
	logic [16:0]          div_sum;
	logic                 src_tick;

	always_comb begin
		n        = q;
		n.tick   = 1'b0;
		src_tick = 1'b0;
		src_step = 17'(`UARTC_SRC_BASE_KHZ >> src_sel);
		src_sum  = {1'b0, q.src_acc} + {1'b0, src_step};
		div_sum  = q.div_acc + `UARTC_HALF_STEP;
		if (restart) begin
			n = '0;
		end else begin
			if (src_sum >= 18'(`UARTC_REF_CLK_KHZ)) begin
				n.src_acc = 17'(src_sum - 18'(`UARTC_REF_CLK_KHZ));
				src_tick  = 1'b1;
			end else begin
				n.src_acc = src_sum[16:0];
			end
			// Divisor in eighths; adding 16 per source tick halves the bit time
			if (src_tick && (divisor != 16'h0000)) begin
				if (div_sum >= {1'b0, divisor}) begin
					n.div_acc = div_sum - {1'b0, divisor};
					n.tick    = 1'b1;
				end else begin
					n.div_acc = div_sum;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else if (clk_en) begin
			q <= n;
		end
	end

	assign half_tick = q.tick & clk_en;

endmodule // uartc_baud

/* File: verilog/uartc_core.sv */
`timescale 1ns/1ps
`include "uartc_defines.svh"
module uartc_core import uartc_pkg::*; (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              clk_en,
	// Register port
	input  wire uartc_bus_req_type bus_req,
	output logic [31:0]            bus_rdata,
	// Transmit side
	input  wire logic              tx_valid,
	input  wire logic [7:0]        tx_data,
	output logic                   tx_ready,
	// Receive side
	output logic                   rx_valid,
	output logic [7:0]             rx_data,
	// Serial pins
	output logic                   txd,
	input  wire logic              rxd,
	input  wire logic              cts_n,
	// Interrupt
	output logic                   irq
);

	// ----------------------------------------------------------------
	// Reset image
	// ----------------------------------------------------------------
	localparam uartc_state_type RESET_STATE = '{
		fmt:       uartc_fmt_type'(`UARTC_FMT_RESET),
		baud:      `UARTC_BAUD_RESET,
		src:       `UARTC_SRC_RESET,
		idle:      `UARTC_IDLE_RESET,
		mask:      `UARTC_MASK_RESET,
		stat:      8'h00,
		rdata:     32'h0000_0000,
		rxd_sync:  3'h7,
		rxd_f:     1'b1,
		cts_sync:  3'h7,
		cts_f:     1'b1,
		tx_st:     TX_IDLE,
		tx_shift:  12'hfff,
		tx_cnt:    4'h0,
		tx_half:   1'b0,
		txd:       1'b1,
		rx_st:     RX_IDLE,
		rx_shift:  8'h00,
		rx_cnt:    3'h0,
		rx_half:   1'b0,
		rx_par:    1'b0,
		rx_valid:  1'b0,
		rx_data:   8'h00,
		tmo_cnt:   `UARTC_IDLE_RESET,
		tmo_armed: 1'b0,
		tmo_half:  1'b0
	};

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic par_bit(input logic [1:0] kind, input logic [7:0] d);
		logic r;
		case (kind)
			2'h0:    r = ^d;
			2'h1:    r = ~^d;
			2'h2:    r = 1'b0;
			default: r = 1'b1;
		endcase
		return r;
	endfunction

	function automatic logic [3:0] data_bits(input uartc_fmt_type f);
		return f.char_len_sel ? 4'h7 : 4'h8;
	endfunction

	function automatic logic [7:0] char_mask(input uartc_fmt_type f, input logic [7:0] d);
		return f.char_len_sel ? {1'b0, d[6:0]} : d;
	endfunction

	// Serialised frame, bit 0 goes out first; unused high bits stay at idle
	function automatic logic [11:0] tx_frame(input uartc_fmt_type f, input logic [7:0] d);
		logic [11:0] v;
		logic [7:0]  m;
		m    = char_mask(f, d);
		v    = 12'hfff;
		v[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < data_bits(f)) begin
				v[i + 1] = m[i];
			end
		end
		if (f.par_on) begin
			v[data_bits(f) + 4'h1] = par_bit(f.par_kind, m);
		end
		return v;
	endfunction

	function automatic logic [3:0] tx_len(input uartc_fmt_type f);
		return 4'h1 + data_bits(f) + {3'h0, f.par_on} + (f.stop2 ? 4'h2 : 4'h1);
	endfunction

	// ----------------------------------------------------------------
	// State and scratch
	// ----------------------------------------------------------------
	uartc_state_type q;
	uartc_state_type n;
	logic            tx_go;
	logic            tx_tick;
	logic            rx_tick;
	logic            rx_restart;
	logic            rd_stat;
	logic            char_done;
	logic [7:0]      stat_set;
	logic [7:0]      stat_clr;
	logic [7:0]      rx_char;
	logic [2:0]      rx_last;

	// ----------------------------------------------------------------
	// Bit clocks
	// ----------------------------------------------------------------
	// Separate generators: transmit restarts on each character, receive
	// restarts on each start edge so sampling lands mid-bit.
	uartc_baud u_tx_baud (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.src_sel   (q.src),
		.divisor   (q.baud),
		.restart   (tx_go),
		.half_tick (tx_tick)
	);

	uartc_baud u_rx_baud (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.src_sel   (q.src),
		.divisor   (q.baud),
		.restart   (rx_restart),
		.half_tick (rx_tick)
	);

	// ----------------------------------------------------------------
	// Handshake
	// ----------------------------------------------------------------
	assign tx_ready = clk_en && (q.tx_st == TX_IDLE) &&
		(!q.fmt.cts_gate || !q.cts_f);
	assign tx_go    = tx_valid && tx_ready;
	assign rx_char  = char_mask(q.fmt, q.fmt.char_len_sel ? {1'b0, q.rx_shift[7:1]} :
		q.rx_shift);
	assign rx_last  = q.fmt.char_len_sel ? 3'h6 : 3'h7;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n          = q;
		n.rdata    = 32'h0000_0000;
		n.rx_valid = 1'b0;
		rd_stat    = 1'b0;
		char_done  = 1'b0;
		rx_restart = 1'b0;
		stat_set   = 8'h00;
		stat_clr   = 8'h00;

		// Pin synchronisers: a change counts once stages two and three agree
		n.rxd_sync = {q.rxd_sync[1:0], rxd};
		n.cts_sync = {q.cts_sync[1:0], cts_n};
		if (q.rxd_sync[2] == q.rxd_sync[1]) begin
			n.rxd_f = q.rxd_sync[2];
		end
		if (q.cts_sync[2] == q.cts_sync[1]) begin
			n.cts_f = q.cts_sync[2];
		end

		// Register reads
		if (bus_req.rd) begin
			if (bus_req.addr == `UARTC_ADDR_FMT) begin
				n.rdata = {26'h0, q.fmt};
			end else if (bus_req.addr == `UARTC_ADDR_BAUD) begin
				n.rdata = {16'h0, q.baud};
			end else if (bus_req.addr == `UARTC_ADDR_SRC) begin
				n.rdata = {30'h0, q.src};
			end else if (bus_req.addr == `UARTC_ADDR_IDLE) begin
				n.rdata = {24'h0, q.idle};
			end else if (bus_req.addr == `UARTC_ADDR_STATUS) begin
				n.rdata = {24'h0, q.stat};
				rd_stat = 1'b1;
			end else if (bus_req.addr == `UARTC_ADDR_MASK) begin
				n.rdata = {24'h0, q.mask};
			end
		end

		// Register writes
		if (bus_req.wr) begin
			if (bus_req.addr == `UARTC_ADDR_FMT) begin
				n.fmt = uartc_fmt_type'(bus_req.wdata[5:0]);
			end else if (bus_req.addr == `UARTC_ADDR_BAUD) begin
				n.baud = bus_req.wdata[15:0];
			end else if (bus_req.addr == `UARTC_ADDR_SRC) begin
				n.src = bus_req.wdata[1:0];
			end else if (bus_req.addr == `UARTC_ADDR_IDLE) begin
				n.idle = bus_req.wdata[7:0];
			end else if (bus_req.addr == `UARTC_ADDR_STATUS) begin
				stat_clr = bus_req.wdata[7:0];
			end else if (bus_req.addr == `UARTC_ADDR_MASK) begin
				n.mask = bus_req.wdata[7:0];
			end
		end

		// Transmitter
		case (q.tx_st)
			TX_IDLE: begin
				if (tx_go) begin
					n.tx_shift = tx_frame(q.fmt, tx_data);
					n.tx_cnt   = tx_len(q.fmt);
					n.txd      = 1'b0;
					n.tx_half  = 1'b0;
					n.tx_st    = TX_SEND;
				end
			end
			TX_SEND: begin
				if (tx_tick) begin
					n.tx_half = ~q.tx_half;
					if (q.tx_half) begin
						n.tx_shift = {1'b1, q.tx_shift[11:1]};
						n.txd      = q.tx_shift[1];
						n.tx_cnt   = q.tx_cnt - 4'h1;
						if (q.tx_cnt == 4'h1) begin
							n.txd   = 1'b1;
							n.tx_st = TX_IDLE;
						end
					end
				end
			end
			default: begin
				n.tx_st = TX_IDLE;
			end
		endcase

		// Receiver
		case (q.rx_st)
			RX_IDLE: begin
				if (!q.rxd_f) begin
					rx_restart = 1'b1;
					n.rx_st    = RX_START;
				end
			end
			RX_START: begin
				// First half tick lands mid start bit; a high line there was a glitch
				if (rx_tick) begin
					if (!q.rxd_f) begin
						n.rx_half = 1'b0;
						n.rx_cnt  = 3'h0;
						n.rx_st   = RX_DATA;
					end else begin
						n.rx_st = RX_IDLE;
					end
				end
			end
			RX_DATA: begin
				if (rx_tick) begin
					n.rx_half = ~q.rx_half;
					if (q.rx_half) begin
						n.rx_shift = {q.rxd_f, q.rx_shift[7:1]};
						n.rx_cnt   = q.rx_cnt + 3'h1;
						if (q.rx_cnt == rx_last) begin
							n.rx_st = q.fmt.par_on ? RX_PARITY : RX_STOP;
						end
					end
				end
			end
			RX_PARITY: begin
				if (rx_tick) begin
					n.rx_half = ~q.rx_half;
					if (q.rx_half) begin
						n.rx_par = q.rxd_f;
						n.rx_st  = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				// Only the first stop bit is checked; a second one looks like idle
				if (rx_tick) begin
					n.rx_half = ~q.rx_half;
					if (q.rx_half) begin
						char_done  = 1'b1;
						n.rx_valid = 1'b1;
						n.rx_data  = rx_char;
						n.rx_st    = RX_IDLE;
						if (!q.rxd_f) begin
							stat_set[`UARTC_ST_FRAME] = 1'b1;
						end
						if (q.fmt.par_on && (q.rx_par != par_bit(q.fmt.par_kind, rx_char)))
						begin
							stat_set[`UARTC_ST_PARITY] = 1'b1;
						end
					end
				end
			end
			default: begin
				n.rx_st = RX_IDLE;
			end
		endcase

		// Idle timeout, counted in bit times while the receiver is idle
		if (rd_stat || char_done) begin
			n.tmo_cnt   = q.idle;
			n.tmo_armed = 1'b1;
			n.tmo_half  = 1'b0;
		end else if (q.tmo_armed && (q.rx_st == RX_IDLE) && rx_tick) begin
			n.tmo_half = ~q.tmo_half;
			if (q.tmo_half) begin
				if (q.tmo_cnt <= 8'h01) begin
					n.tmo_cnt   = 8'h00;
					n.tmo_armed = 1'b0;
					stat_set[`UARTC_ST_TIMEOUT] = 1'b1;
				end else begin
					n.tmo_cnt = q.tmo_cnt - 8'h01;
				end
			end
		end

		// Sticky flags: a new event wins over a read or write-one clear
		if (rd_stat) begin
			stat_clr = 8'hff;
		end
		n.stat = ((q.stat & ~stat_clr) | stat_set) & `UARTC_ST_IMPL;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q <= RESET_STATE;
		end else if (clk_en) begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_rdata = q.rdata;
	assign rx_valid  = q.rx_valid;
	assign rx_data   = q.rx_data;
	assign txd       = q.txd;
	assign irq       = |(q.stat & q.mask);

endmodule // uartc_core

/* File: bench/uartc_core_assertions.sv */
`timescale 1ns/1ps
`include "uartc_defines.svh"
module uartc_core_assertions import uartc_pkg::*; (
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              reset,
	input wire logic              clk_en,
	// Register port
	input wire uartc_bus_req_type bus_req,
	input wire logic [31:0]       bus_rdata,
	// Transmit and receive
	input wire logic              tx_valid,
	input wire logic [7:0]        tx_data,
	input wire logic              tx_ready,
	input wire logic              rx_valid,
	input wire logic [7:0]        rx_data,
	// Pins
	input wire logic              txd,
	input wire logic              rxd,
	input wire logic              cts_n,
	input wire logic              irq
);
	// ------------------------------------------------------------
	// Shadow of the written configuration
	// ------------------------------------------------------------
	logic [7:0] mask_q;
	logic       gate_q;
	logic       seven_q;
	logic       wr_en;
	logic       st_rd;
	assign wr_en = bus_req.wr && clk_en;
	assign st_rd = bus_req.rd && clk_en && bus_req.addr == `UARTC_ADDR_STATUS;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mask_q  <= 8'h00;
			gate_q  <= 1'b0;
			seven_q <= 1'b0;
		end else if (wr_en && bus_req.addr == `UARTC_ADDR_MASK) begin
			mask_q <= bus_req.wdata[7:0];
		end else if (wr_en && bus_req.addr == `UARTC_ADDR_FMT) begin
			gate_q  <= bus_req.wdata[5];
			seven_q <= bus_req.wdata[0];
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_accept;
		tx_valid && tx_ready && clk_en;
	endsequence
	// A flag set in the first read's own cycle may legally show, hence rx_valid
	sequence s_two_reads;
		st_rd ##1 (st_rd && !rx_valid);
	endsequence
	a_start_after_accept: assert property (s_accept |=> !txd && !tx_ready)
		else $error("start bit or busy missing after accept");
	a_idle_line_high: assert property (tx_ready |-> txd)
		else $error("line not high while transmitter idle");
	a_bit_min_width: assert property ($fell(txd) |-> !txd [*8])
		else $error("low bit shorter than the minimum bit time");
	a_gate_blocks_tx: assert property ((gate_q && cts_n) [*5] |-> !tx_ready)
		else $error("transmit offered without permission");
	a_gate_off_ready: assert property ((!gate_q && clk_en ##1 !gate_q && clk_en
		&& $fell(tx_ready)) |-> $past(tx_valid))
		else $error("ready dropped with flow control off");
	a_seven_bit_msb: assert property (rx_valid && seven_q |-> !rx_data[7])
		else $error("seven-bit character with top bit set");
	a_status_read_clears: assert property (s_two_reads |=> bus_rdata[7] == 1'b0
		&& bus_rdata[5] == 1'b0)
		else $error("error flags survived a status read");
	a_irq_masked: assert property (irq |-> mask_q != 8'h00 || $past(mask_q) != 8'h00)
		else $error("interrupt with every source masked");
endmodule // uartc_core_assertions

bind uartc_core uartc_core_assertions chk (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
	.bus_req(bus_req), .bus_rdata(bus_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .txd(txd), .rxd(rxd),
	.cts_n(cts_n), .irq(irq));

/* File: bench/uartc_far_end.sv */
`timescale 1ns/1ps
module uartc_far_end (
	// Serial pins
	input  wire logic txd,
	output logic      rxd,
	output logic      cts_n
);
	// ------------------------------------------------------------
	// Remote serial party
	// ------------------------------------------------------------
	real         bit_ns = 76.923;
	logic [11:0] cap_q;
	int          n_cap = 0;
	// Idle line high as with a pull-up; sending permitted until told otherwise
	initial begin
		rxd = 1'b1;
		cts_n = 1'b0;
	end
	// Sample twelve bit middles, so a frame of any format fits
	always @(negedge txd) begin
		#(bit_ns / 2);
		for (int i = 0; i < 12; i++) begin
			cap_q[i] = txd;
			#(bit_ns);
		end
		n_cap++;
	end
	task automatic send(input logic [11:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			rxd = b[i];
			#(bit_ns);
		end
		rxd = 1'b1;
	endtask
	task automatic permit(input logic on, input int dly_ns);
		#(dly_ns);
		cts_n = ~on;
	endtask
endmodule // uartc_far_end

/* File: bench/tb_uart_line_config_baud_timeout.sv */
`timescale 1ns/1ps
`include "uartc_defines.svh"
module tb_uart_line_config_baud_timeout import uartc_pkg::*; ;
	logic              ref_clk;
	logic              reset;
	logic              clk_en;
	uartc_bus_req_type bus_req;
	logic [31:0]       bus_rdata;
	logic              tx_valid;
	logic [7:0]        tx_data;
	logic              tx_ready;
	logic              rx_valid;
	logic [7:0]        rx_data;
	logic              txd;
	logic              rxd;
	logic              cts_n;
	logic              irq;
	int                n_fail = 0;
	int                checks = 0;
	int                wt;
	int                bz;
	int                n;
	int                k;
	logic [31:0]       lfsr_q = 32'hb910;
	logic [31:0]       rdv;
	logic [31:0]       rdv2;
	logic [11:0]       ef;
	logic [31:0]       adr[7] = '{`UARTC_ADDR_STATUS, `UARTC_ADDR_MASK, `UARTC_ADDR_IDLE,
		`UARTC_ADDR_FMT, `UARTC_ADDR_BAUD, `UARTC_ADDR_SRC, 32'h4000_4030};
	logic [31:0]       rst[7] = '{32'h0, 32'h0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [31:0]       wm[7] = '{32'h0, 32'hff, 32'hff, 32'h3f, 32'hffff, 32'h3, 32'h0};
	logic [5:0]        fl[8] = '{6'h00, 6'h01, 6'h02, 6'h06, 6'h0a, 6'h0e, 6'h13, 6'h1f};
	int                bsrc[6] = '{0, 1, 2, 3, 0, 0};
	int                bdiv[6] = '{16, 16, 16, 16, 28, 40};

	uartc_core uut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .txd(txd), .rxd(rxd), .cts_n(cts_n), .irq(irq));
	uartc_far_end far (.txd(txd), .rxd(rxd), .cts_n(cts_n));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// ------------------------------------------------------------
	// Reference model and helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [11:0] frame(input logic [7:0] d, input logic [5:0] f,
		output int nb);
		logic [11:0] b;
		logic        p;
		b = 12'hffe;
		p = 1'b0;
		for (int i = 0; i < (f[0] ? 7 : 8); i++) begin
			b[1 + i] = d[i];
			p ^= d[i];
		end
		nb = f[0] ? 8 : 9;
		if (f[1]) begin
			b[nb] = f[3] ? f[2] : p ^ f[2];
			nb++;
		end
		nb += f[4] ? 2 : 1;
		return b;
	endfunction
	// Cycles of a frame: nb bits of div/8 source periods, source 26 MHz over 2**src
	function automatic int span(input int nb, input int dv, input int src);
		return int'(nb * dv * (2 ** src) * 1000.0 / 1664.0);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Source clock is emulated by a phase accumulator, so allow a few cycles
	task automatic chk_near(input string nm, input int e, input int g);
		checks++;
		if (g < e - 4 || g > e + 4) begin
			n_fail++;
			$display("ERROR %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req <= '0;
		@(posedge ref_clk);
	endtask
	// Two reads back to back; each answer is taken mid-cycle while it stands
	task automatic rd(input logic [31:0] a);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		@(negedge ref_clk);
		rdv = bus_rdata;
		@(posedge ref_clk);
		bus_req <= '0;
		@(negedge ref_clk);
		rdv2 = bus_rdata;
		@(posedge ref_clk);
	endtask
	task automatic tx_one(input logic [7:0] d);
		tx_data <= d;
		tx_valid <= 1'b1;
		wt = 0;
		@(posedge ref_clk);
		while (tx_ready !== 1'b1 && wt < 3000) begin
			@(posedge ref_clk);
			wt++;
		end
		tx_valid <= 1'b0;
		bz = 0;
		do begin
			@(posedge ref_clk);
			bz++;
		end while (tx_ready !== 1'b1 && bz < 3000);
	endtask
	task automatic rx_one(input logic [7:0] d, input logic [5:0] f, input logic bad);
		logic [11:0] b;
		int          nb;
		int          s;
		b = frame(d, f, nb);
		s = nb - (f[4] ? 2 : 1);
		if (bad && f[1]) b[s - 1] = ~b[s - 1];
		if (bad && !f[1]) b[s] = 1'b0;
		fork
			far.send(b, nb);
			begin
				wt = 0;
				do begin
					@(posedge ref_clk);
					wt++;
				end while (rx_valid !== 1'b1 && wt < 400);
				chk("rx_data", d & {~f[0], 7'h7f}, rx_data);
			end
		join
		@(posedge ref_clk);
		rd(`UARTC_ADDR_STATUS);
		chk("status", bad ? (f[1] ? 32'h20 : 32'h80) : 32'h0, rdv & 32'ha0);
		chk("status reread", 32'h0, rdv2 & 32'ha0);
	endtask
	task automatic summarize();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		#400000;
		n_fail++;
		summarize();
	end
	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		bus_req = '0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		foreach (adr[i]) begin
			rd(adr[i]);
			chk("reset value", rst[i], rdv);
			wr(adr[i], 32'hffff_ffff);
			rd(adr[i]);
			chk("written value", wm[i], rdv);
		end
		chk("irq idle", 1'b0, irq);
		wr(`UARTC_ADDR_MASK, 32'h0);
		wr(`UARTC_ADDR_BAUD, 32'h10);
		wr(`UARTC_ADDR_SRC, 32'h0);
		foreach (fl[i]) begin
			wr(`UARTC_ADDR_FMT, {26'h0, fl[i]});
			lfsr_q = nxt(lfsr_q);
			ef = frame(lfsr_q[7:0], fl[i], n);
			k = far.n_cap;
			tx_one(lfsr_q[7:0]);
			chk_near("frame length", span(n, 16, 0), bz);
			wt = 0;
			while (far.n_cap == k && wt < 500) begin
				@(posedge ref_clk);
				wt++;
			end
			chk("frame bits", ef, far.cap_q);
			rx_one(lfsr_q[15:8], fl[i], 1'b0);
			rx_one(lfsr_q[23:16], fl[i], 1'b1);
		end
		far.permit(1'b0, 0);
		wr(`UARTC_ADDR_FMT, 32'h20);
		repeat (10) @(posedge ref_clk);
		chk("ready withheld", 1'b0, tx_ready);
		fork
			far.permit(1'b1, 800);
		join_none
		tx_one(8'h5a);
		chk("held until permitted", 1'b1, wt >= 100 && wt < 110);
		far.permit(1'b0, 0);
		wr(`UARTC_ADDR_FMT, 32'h0);
		repeat (8) @(posedge ref_clk);
		tx_one(8'ha5);
		chk("permission ignored", 1'b1, wt < 2);
		far.permit(1'b1, 0);
		clk_en <= 1'b0;
		@(posedge ref_clk);
		chk("ready frozen", 1'b0, tx_ready);
		clk_en <= 1'b1;
		wr(`UARTC_ADDR_IDLE, 32'h4);
		rd(`UARTC_ADDR_STATUS);
		repeat (6) begin
			repeat (20) @(posedge ref_clk);
			rd(`UARTC_ADDR_STATUS);
			chk("timeout held off", 1'b0, rdv[4]);
		end
		repeat (80) @(posedge ref_clk);
		rd(`UARTC_ADDR_STATUS);
		chk("timeout set", 1'b1, rdv[4]);
		chk("timeout cleared", 1'b0, rdv2[4]);
		repeat (80) @(posedge ref_clk);
		chk("irq masked", 1'b0, irq);
		wr(`UARTC_ADDR_MASK, 32'h10);
		chk("irq raised", 1'b1, irq);
		wr(`UARTC_ADDR_STATUS, 32'h10);
		chk("irq cleared", 1'b0, irq);
		foreach (bsrc[i]) begin
			wr(`UARTC_ADDR_SRC, bsrc[i]);
			wr(`UARTC_ADDR_BAUD, bdiv[i]);
			lfsr_q = nxt(lfsr_q);
			tx_one(lfsr_q[7:0]);
			chk_near("bit timing", span(10, bdiv[i], bsrc[i]), bz);
		end
		summarize();
	end
endmodule // tb_uart_line_config_baud_timeout
